// >>> core/hub_cfg_pkg.sv
// Package: offsets, field positions and reset values of the hub release/power bytes
package hub_cfg_pkg;

   // ------------------------------------------------------------
   // Register offsets in the configuration byte space
   // ------------------------------------------------------------
   localparam logic [7:0] OFS_RELEASE_NUMBER_LOW = 8'h04;
   localparam logic [7:0] OFS_RELEASE_NUMBER_HIGH = 8'h05;
   localparam logic [7:0] OFS_HUB_CONFIG_FIRST = 8'h06;

   // ------------------------------------------------------------
   // Field positions inside the first configuration byte
   // ------------------------------------------------------------
   localparam int BIT_POWER_SOURCE_SELECT = 7;
   localparam int BIT_RESERVED_6 = 6;
   localparam int BIT_HIGH_SPEED_INHIBIT = 5;
   // Bits that hold storage; the reserved bit is left out
   localparam logic [7:0] HUB_CONFIG_FIRST_MASK = 8'hbf;

   // ------------------------------------------------------------
   // Values after reset (load path default of the OEM byte space)
   // ------------------------------------------------------------
   localparam logic [7:0] RST_RELEASE_NUMBER_LOW = 8'h00;
   localparam logic [7:0] RST_RELEASE_NUMBER_HIGH = 8'h00;
   localparam logic [7:0] RST_HUB_CONFIG_FIRST = 8'h00;
   localparam logic [7:0] UNMAPPED_READ_VALUE = 8'h00;

   // Power source encodings of the select bit
   localparam logic POWER_BUS = 1'b0;
   localparam logic POWER_SELF = 1'b1;

   // Number of downstream ports
   localparam int NUM_DOWNSTREAM_PORTS = 7;

endpackage : hub_cfg_pkg

// >>> core/power_source_resolve.sv
// Power source decision: configuration bit or local power-sense pin
`timescale 1ns/10ps

module power_source_resolve
   import hub_cfg_pkg::*;
(
   input wire logic i_power_source_select,
   input wire logic i_dynamic_power_enable,
   input wire logic i_local_power_sense,
   input wire logic i_high_speed_inhibit,
   output logic o_self_powered,
   output logic o_high_speed_allowed
);

   // ------------------------------------------------------------
   // Source selection
   // ------------------------------------------------------------
   // With dynamic switching the stored bit is ignored, so a stale OEM
   // value can never fight the real supply seen on the sense pin
   always_comb
   begin
      if (i_dynamic_power_enable)
      begin
         o_self_powered = i_local_power_sense;
      end
      else
      begin
         o_self_powered = i_power_source_select;
      end
      o_high_speed_allowed = ~i_high_speed_inhibit;
   end

endmodule : power_source_resolve

// >>> core/hub_release_and_power_config.sv
// Release number and first configuration byte of the hub OEM register bank
// ------------------------------------------------------------
// How it works
// - Release number low byte lives in bits 7:0 at offset 04h.
// - Release number high byte lives in bits 7:0 at offset 05h.
// - Both bytes form one 16-bit BCD release number, reported unchanged.
// - Config bit 7 picks power source: 0 bus-powered, 1 self-powered.
// - With dynamic power switching, the local power-sense pin decides instead.
// - When self-powered, every downstream port is made available.
// - Config bit 5 set forbids high-speed attach; hub attaches full-speed only.
// ------------------------------------------------------------
`timescale 1ns/10ps

module hub_release_and_power_config
   import hub_cfg_pkg::*;
#(
   parameter int PORTS = NUM_DOWNSTREAM_PORTS
)
(
   input wire logic i_clk_sys,
   input wire logic i_sys_rst,
   input wire logic i_clk_en,
   // Byte access from the EEPROM loader or the SMBus slave
   input wire logic [7:0] i_cfg_addr,
   input wire logic [7:0] i_cfg_wdata,
   input wire logic i_cfg_wr,
   input wire logic i_cfg_rd,
   output logic [7:0] o_cfg_rdata,
   output logic o_cfg_rvalid,
   // Hub core side
   input wire logic i_dynamic_power_enable,
   input wire logic i_local_power_sense,
   input wire logic [PORTS-1:0] i_bus_port_allow,
   output logic [15:0] o_release_number,
   output logic o_self_powered,
   output logic o_high_speed_inhibit,
   output logic o_high_speed_allowed,
   output logic [PORTS-1:0] o_ports_available
);

   // ------------------------------------------------------------
   // State
   // ------------------------------------------------------------
   typedef struct packed {
      logic [7:0] release_number_low;
      logic [7:0] release_number_high;
      logic [7:0] hub_config_first;
      logic [7:0] rdata;
      logic rvalid;
      logic [15:0] release_number;
      logic self_powered;
      logic hs_inhibit;
      logic hs_allowed;
      logic [PORTS-1:0] ports_available;
   } cfg_state_t;

   cfg_state_t st;
   cfg_state_t next_st;
   logic resolved_self;
   logic resolved_hs_allowed;
   logic [PORTS-1:0] port_next;

   // ------------------------------------------------------------
   // Power source and speed decode
   // ------------------------------------------------------------
   power_source_resolve u_resolve (
      .i_power_source_select(st.hub_config_first[BIT_POWER_SOURCE_SELECT]),
      .i_dynamic_power_enable(i_dynamic_power_enable),
      .i_local_power_sense(i_local_power_sense),
      .i_high_speed_inhibit(st.hub_config_first[BIT_HIGH_SPEED_INHIBIT]),
      .o_self_powered(resolved_self),
      .o_high_speed_allowed(resolved_hs_allowed)
   );

   // Per-port availability: self power opens every port
   genvar gp;
   generate
      for (gp = 0; gp < PORTS; gp++)
      begin : g_port
         assign port_next[gp] = resolved_self | i_bus_port_allow[gp];
      end
   endgenerate

   // ------------------------------------------------------------
   // Next state
   // ------------------------------------------------------------
   // A read in the same cycle as a write returns the old byte; the
   // loader never mixes both on one byte, so no bypass is spent on it
   always_comb
   begin
      next_st = st;
      next_st.rvalid = 1'b0;
      if (i_cfg_wr)
      begin
         case (i_cfg_addr)
            OFS_RELEASE_NUMBER_LOW: next_st.release_number_low = i_cfg_wdata;
            OFS_RELEASE_NUMBER_HIGH: next_st.release_number_high = i_cfg_wdata;
            OFS_HUB_CONFIG_FIRST:
               next_st.hub_config_first = i_cfg_wdata & HUB_CONFIG_FIRST_MASK;
            default: next_st.hub_config_first = st.hub_config_first;
         endcase
      end
      if (i_cfg_rd)
      begin
         next_st.rvalid = 1'b1;
         case (i_cfg_addr)
            OFS_RELEASE_NUMBER_LOW: next_st.rdata = st.release_number_low;
            OFS_RELEASE_NUMBER_HIGH: next_st.rdata = st.release_number_high;
            OFS_HUB_CONFIG_FIRST: next_st.rdata = st.hub_config_first;
            default: next_st.rdata = UNMAPPED_READ_VALUE;
         endcase
      end
      // BCD value passes through untouched, no digit checking
      next_st.release_number = {st.release_number_high, st.release_number_low};
      next_st.self_powered = resolved_self;
      next_st.hs_inhibit = st.hub_config_first[BIT_HIGH_SPEED_INHIBIT];
      next_st.hs_allowed = resolved_hs_allowed;
      next_st.ports_available = port_next;
   end

   // ------------------------------------------------------------
   // Registers; clock enable low freezes everything but reset
   // ------------------------------------------------------------
   always_ff @(posedge i_clk_sys)
   begin
      if (i_sys_rst)
      begin
         st <= '0;
         st.release_number_low <= RST_RELEASE_NUMBER_LOW;
         st.release_number_high <= RST_RELEASE_NUMBER_HIGH;
         st.hub_config_first <= RST_HUB_CONFIG_FIRST;
         st.rdata <= UNMAPPED_READ_VALUE;
         st.hs_allowed <= 1'b1;
      end
      else if (i_clk_en)
      begin
         st <= next_st;
      end
   end

   // Outputs come straight from the state flops
   assign o_cfg_rdata = st.rdata;
   assign o_cfg_rvalid = st.rvalid;
   assign o_release_number = st.release_number;
   assign o_self_powered = st.self_powered;
   assign o_high_speed_inhibit = st.hs_inhibit;
   assign o_high_speed_allowed = st.hs_allowed;
   assign o_ports_available = st.ports_available;

   // ------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------
   default clocking cb @(posedge i_clk_sys); endclocking
   default disable iff (i_sys_rst);

   sequence s_write(logic [7:0] ofs);
      i_clk_en && i_cfg_wr && !i_cfg_rd && i_cfg_addr == ofs;
   endsequence

   sequence s_read(logic [7:0] ofs);
      i_clk_en && i_cfg_rd && !i_cfg_wr && i_cfg_addr == ofs;
   endsequence

   property p_low_store;
      s_write(OFS_RELEASE_NUMBER_LOW) |=> st.release_number_low == $past(i_cfg_wdata);
   endproperty
   a_low_store: assert property (p_low_store) else $error("low byte not stored");

   property p_high_readback;
      s_write(OFS_RELEASE_NUMBER_HIGH) ##1 s_read(OFS_RELEASE_NUMBER_HIGH)
         |=> o_cfg_rvalid && o_cfg_rdata == $past(i_cfg_wdata, 2);
   endproperty
   a_high_readback: assert property (p_high_readback) else $error("high byte readback");

   property p_release_value;
      i_clk_en |=> o_release_number == $past({st.release_number_high, st.release_number_low});
   endproperty
   a_release_value: assert property (p_release_value) else $error("release number");

   property p_power_bit;
      i_clk_en && !i_dynamic_power_enable
         |=> o_self_powered == $past(st.hub_config_first[BIT_POWER_SOURCE_SELECT]);
   endproperty
   a_power_bit: assert property (p_power_bit) else $error("power bit not used");

   property p_power_pin;
      i_clk_en && i_dynamic_power_enable |=> o_self_powered == $past(i_local_power_sense);
   endproperty
   a_power_pin: assert property (p_power_pin) else $error("sense pin not used");

   property p_ports_open;
      i_clk_en && resolved_self |=> o_self_powered && &o_ports_available;
   endproperty
   a_ports_open: assert property (p_ports_open) else $error("ports not all open");

   property p_speed;
      i_clk_en |=> o_high_speed_allowed == !$past(st.hub_config_first[BIT_HIGH_SPEED_INHIBIT])
         && o_high_speed_inhibit != o_high_speed_allowed;
   endproperty
   a_speed: assert property (p_speed) else $error("speed inhibit wrong");

   property p_reserved;
      s_write(OFS_HUB_CONFIG_FIRST) ##1 s_read(OFS_HUB_CONFIG_FIRST)
         |=> o_cfg_rdata[BIT_RESERVED_6] == 1'b0
         && o_cfg_rdata[BIT_HIGH_SPEED_INHIBIT] == $past(i_cfg_wdata[BIT_HIGH_SPEED_INHIBIT], 2);
   endproperty
   a_reserved: assert property (p_reserved) else $error("reserved bit visible");

   // Back-to-back write and read of the low byte sees the new value
   property p_low_readback;
      s_write(OFS_RELEASE_NUMBER_LOW) ##1 s_read(OFS_RELEASE_NUMBER_LOW)
         |=> o_cfg_rvalid && o_cfg_rdata == $past(i_cfg_wdata, 2);
   endproperty
   a_low_readback: assert property (p_low_readback) else $error("low byte readback");

   // The reserved bit never reaches storage, whatever the loader sends
   property p_reserved_zero;
      st.hub_config_first[BIT_RESERVED_6] == 1'b0;
   endproperty
   a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bit stored");

endmodule : hub_release_and_power_config

// >>> test/cfg_loader.sv
// Loader model: byte writes and reads as the EEPROM loader or SMBus master makes them
`timescale 1ns/10ps

module cfg_loader
(
   input wire logic i_clk_sys,
   output logic [7:0] o_addr,
   output logic [7:0] o_wdata,
   output logic o_wr,
   output logic o_rd
);
   // Strobes idle low from time zero
   initial
   begin
      o_addr = 8'hff;
      o_wdata = 8'h00;
      o_wr = 1'b0;
      o_rd = 1'b0;
   end

   // One byte per strobe, held across the sampling edge.
   // On release the strobes drop low and address and data are inverted, so a stale byte never looks valid.
   task automatic xfer(input logic [7:0] a, input logic [7:0] d, input logic is_rd);
   begin
      @(negedge i_clk_sys);
      o_addr = a;
      o_wdata = d;
      o_wr = ~is_rd;
      o_rd = is_rd;
      @(negedge i_clk_sys);
      o_wr = 1'b0;
      o_rd = 1'b0;
      o_addr = ~a;
      o_wdata = ~d;
   end
   endtask : xfer

   // Write then read of one byte on two adjacent edges, as a burst loader may do
   task automatic wr_then_rd(input logic [7:0] a, input logic [7:0] d);
   begin
      @(negedge i_clk_sys);
      o_addr = a;
      o_wdata = d;
      o_wr = 1'b1;
      o_rd = 1'b0;
      @(negedge i_clk_sys);
      o_wr = 1'b0;
      o_rd = 1'b1;
      @(negedge i_clk_sys);
      o_rd = 1'b0;
      o_addr = ~a;
      o_wdata = ~d;
   end
   endtask : wr_then_rd
endmodule : cfg_loader

// >>> test/tb_top.sv
// Testbench for the release number and first configuration byte
`timescale 1ns/10ps

module tb_top;
   import hub_cfg_pkg::*;
   logic clk, rst, en, dyn, sense, rvalid, self_pw, hs_inh, hs_ok, wr, rd;
   logic [7:0] addr, wdata, rdata;
   logic [6:0] allow, ports;
   logic [15:0] rel;
   int error_cnt = 0;
   int checks = 0;

   // ---------------------------------------------
   // Clock, loader and device
   // ---------------------------------------------
   initial
   begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   cfg_loader loader (.i_clk_sys(clk), .o_addr(addr), .o_wdata(wdata), .o_wr(wr), .o_rd(rd));
   hub_release_and_power_config dut (.i_clk_sys(clk), .i_sys_rst(rst), .i_clk_en(en),
      .i_cfg_addr(addr), .i_cfg_wdata(wdata), .i_cfg_wr(wr), .i_cfg_rd(rd),
      .o_cfg_rdata(rdata), .o_cfg_rvalid(rvalid), .i_dynamic_power_enable(dyn),
      .i_local_power_sense(sense), .i_bus_port_allow(allow), .o_release_number(rel),
      .o_self_powered(self_pw), .o_high_speed_inhibit(hs_inh),
      .o_high_speed_allowed(hs_ok), .o_ports_available(ports));

   // ---------------------------------------------
   // Shared helpers
   // ---------------------------------------------
   task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
   begin
      checks++;
      if (seen !== exp)
      begin
         error_cnt++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   end
   endtask : chk

   // Read one byte and compare it in the cycle its valid pulse stands
   task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
   begin
      loader.xfer(a, 8'h00, 1'b1);
      chk("rvalid", {15'h0, rvalid}, 16'h1);
      chk("rdata", {8'h0, rdata}, {8'h0, exp});
   end
   endtask : rd_chk

   // Write then read the same byte on back-to-back edges
   task automatic rw_chk(input logic [7:0] a, input logic [7:0] d, input logic [7:0] exp);
   begin
      loader.wr_then_rd(a, d);
      chk("rvalid", {15'h0, rvalid}, 16'h1);
      chk("rdata", {8'h0, rdata}, {8'h0, exp});
   end
   endtask : rw_chk

   // Config writes reach the hub outputs two edges later
   task automatic settle();
   begin
      repeat (2) @(negedge clk);
   end
   endtask : settle

   // Power outputs as one word: self, inhibit, allowed, ports
   task automatic pw_chk(input logic [9:0] exp);
   begin
      chk("power", {6'h0, self_pw, hs_inh, hs_ok, ports}, {6'h0, exp});
   end
   endtask : pw_chk

   // ---------------------------------------------
   // Scenarios
   // ---------------------------------------------
   task automatic t_reset();
   begin
      rd_chk(OFS_RELEASE_NUMBER_LOW, RST_RELEASE_NUMBER_LOW);
      rd_chk(OFS_RELEASE_NUMBER_HIGH, RST_RELEASE_NUMBER_HIGH);
      rd_chk(OFS_HUB_CONFIG_FIRST, RST_HUB_CONFIG_FIRST);
      chk("release", rel, 16'h0000);
      pw_chk({3'b001, allow});
      $display("test reset done");
   end
   endtask : t_reset

   // BCD value written byte by byte, read back and reported unchanged
   task automatic t_release();
   begin
      loader.xfer(OFS_RELEASE_NUMBER_LOW, 8'h59, 1'b0);
      loader.xfer(OFS_RELEASE_NUMBER_HIGH, 8'h98, 1'b0);
      settle();
      chk("release", rel, 16'h9859);
      rd_chk(OFS_RELEASE_NUMBER_LOW, 8'h59);
      rd_chk(OFS_RELEASE_NUMBER_HIGH, 8'h98);
      rw_chk(OFS_RELEASE_NUMBER_LOW, 8'h59, 8'h59);
      rw_chk(OFS_RELEASE_NUMBER_HIGH, 8'h98, 8'h98);
      loader.xfer(8'h07, 8'h77, 1'b0);
      rd_chk(8'h07, UNMAPPED_READ_VALUE);
      chk("release", rel, 16'h9859);
      $display("test release done");
   end
   endtask : t_release

   // Power source and speed bits, reserved bit reads zero
   task automatic t_config();
   begin
      loader.xfer(OFS_HUB_CONFIG_FIRST, 8'hff, 1'b0);
      settle();
      rd_chk(OFS_HUB_CONFIG_FIRST, 8'hbf);
      pw_chk({3'b110, 7'h7f});
      loader.xfer(OFS_HUB_CONFIG_FIRST, 8'h40, 1'b0);
      settle();
      rd_chk(OFS_HUB_CONFIG_FIRST, 8'h00);
      pw_chk({3'b001, allow});
      loader.xfer(OFS_HUB_CONFIG_FIRST, 8'h20, 1'b0);
      settle();
      pw_chk({3'b010, allow});
      rw_chk(OFS_HUB_CONFIG_FIRST, 8'h60, 8'h20);
      $display("test config done");
   end
   endtask : t_config

   // Sense pin overrides the select bit both ways
   task automatic t_dynamic();
   begin
      dyn = 1'b1;
      sense = 1'b1;
      settle();
      chk("self", {15'h0, self_pw}, 16'h1);
      loader.xfer(OFS_HUB_CONFIG_FIRST, 8'h80, 1'b0);
      sense = 1'b0;
      settle();
      pw_chk({3'b001, allow});
      dyn = 1'b0;
      settle();
      pw_chk({3'b101, 7'h7f});
      $display("test dynamic done");
   end
   endtask : t_dynamic

   // Clock enable low: loader strobes are not taken, outputs hold
   task automatic t_freeze();
   begin
      en = 1'b0;
      loader.xfer(OFS_RELEASE_NUMBER_LOW, 8'h12, 1'b0);
      settle();
      chk("release", rel, 16'h9859);
      en = 1'b1;
      rd_chk(OFS_RELEASE_NUMBER_LOW, 8'h59);
      $display("test freeze done");
   end
   endtask : t_freeze

   // Reset again in mid-run: hub outputs and stored bytes return to reset values
   task automatic t_rerst();
   begin
      rst = 1'b1;
      @(negedge clk);
      pw_chk({3'b001, 7'h00});
      rst = 1'b0;
      t_reset();
      $display("test mid-run reset done");
   end
   endtask : t_rerst

   task automatic end_sim();
   begin
      $display("checks %0d mismatches %0d", checks, error_cnt);
      if (error_cnt == 0 && checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   end
   endtask : end_sim

   // Main sequence; inputs set before the first edge
   initial
   begin
      rst = 1'b1;
      en = 1'b1;
      dyn = 1'b0;
      sense = 1'b0;
      allow = 7'h55;
      repeat (8) @(negedge clk);
      rst = 1'b0;
      t_reset();
      t_release();
      t_config();
      t_dynamic();
      t_freeze();
      t_rerst();
      end_sim();
   end

   // Whole run is well under a thousand cycles
   initial
   begin
      #20000;
      error_cnt++;
      end_sim();
   end
endmodule : tb_top
